// ---- hdl/port_pkg.sv ----
package port_pkg;

  // port set, narrowest first so the first enabled match owns a pin
  localparam int NUM_PORTS            = 6;
  localparam int NUM_PINS             = 32;
  localparam int NUM_CLKBLK           = 6;
  localparam int PORT_W  [NUM_PORTS]  = '{1, 1, 4, 8, 16, 32};
  localparam int PORT_LO [NUM_PORTS]  = '{0, 1, 0, 0, 0, 0};
  localparam logic [2:0] NO_OWNER     = 3'h6;

  // serial link claim on shared pins
  localparam int LINK_LO              = 24;
  localparam int LINK_W               = 4;

  // reference clock
  localparam int REF_PERIOD_NS        = 40;
  localparam int COUNT_W              = 16;

  // address map (byte addresses)
  localparam logic [3:0]  AREA_PORT   = 4'h0;
  localparam logic [3:0]  AREA_CLKBLK = 4'h1;
  localparam logic [11:0] LINK_CTRL   = 12'h200;

  // word index inside a port window of 0x20 bytes
  localparam logic [2:0] REG_CTRL     = 3'h0;
  localparam logic [2:0] REG_DATA     = 3'h1;
  localparam logic [2:0] REG_COND     = 3'h2;
  localparam logic [2:0] REG_TIME     = 3'h3;
  localparam logic [2:0] REG_COUNT    = 3'h4;
  localparam logic [2:0] REG_STAMP    = 3'h5;
  localparam logic [2:0] REG_STATUS   = 3'h6;

  // port control fields
  localparam int CTRL_EN              = 0;
  localparam int CTRL_DIR             = 1;
  localparam int CTRL_OC              = 2;
  localparam int CTRL_STB             = 3;
  localparam int CTRL_CLK_LO          = 4;
  localparam int CTRL_COND_LO         = 8;
  localparam logic [31:0] CTRL_MASK   = 32'h0000_037f;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;

  // clock block fields
  localparam int CB_EXT               = 0;
  localparam int CB_PIN               = 1;
  localparam int CB_DIV_LO            = 8;
  localparam int CB_DIV_W             = 8;
  localparam logic [31:0] CB_MASK     = 32'h0000_ff03;
  localparam logic [31:0] CB_RST      = 32'h0000_0000;

  typedef enum logic [1:0] {
    COND_NONE = 2'b00,
    COND_EQ   = 2'b01,
    COND_NE   = 2'b10
  } cond_type;

  typedef enum logic [1:0] {
    XF_IDLE  = 2'b00,
    XF_PEND  = 2'b01,
    XF_READY = 2'b10
  } xfer_state_type;

endpackage

// ---- hdl/port_unit.sv ----
`timescale 1ns/1ps
module port_unit #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  // port clock enable from the selected clock block
  input  wire logic                   tick,
  // register access
  input  wire logic                   wr_en,
  input  wire logic [2:0]             wr_idx,
  input  wire logic [31:0]            wdata,
  input  wire logic [2:0]             rd_idx,
  input  wire logic                   rd_take,
  output logic      [31:0]            rdata,
  // pins
  input  wire logic [W-1:0]           pin_val,
  input  wire logic                   input_strobe,
  output logic      [W-1:0]           out_bits,
  output logic                        output_strobe,
  // status towards the tile
  output logic                        enabled,
  output logic                        drive,
  output logic                        oc_mode,
  output logic      [2:0]             clk_sel,
  output logic                        port_event
);
  import port_pkg::*;

  if (!(W == 1 || W == 4 || W == 8 || W == 16 || W == 32)) begin : g_bad_w
    $error("port width must be 1, 4, 8, 16 or 32");
  end

  logic [31:0]          ctrl_q;
  logic [W-1:0]         xfer_q;
  logic [W-1:0]         out_q;
  logic [W-1:0]         cond_q;
  logic [COUNT_W-1:0]   count_q;
  logic [COUNT_W-1:0]   time_q;
  logic [COUNT_W-1:0]   stamp_q;
  logic                 timed_q;
  logic                 ostb_q;
  xfer_state_type       state_q;
  xfer_state_type       state_d;
  cond_type             cmode;
  logic                 time_ok, cond_ok, stb_ok, do_out, do_in, wr_data;

  // control decode
  assign enabled  = ctrl_q[CTRL_EN];
  assign drive    = ctrl_q[CTRL_EN] & ctrl_q[CTRL_DIR];
  assign oc_mode  = ctrl_q[CTRL_OC];
  assign clk_sel  = ctrl_q[CTRL_CLK_LO +: 3];
  assign cmode    = cond_type'(ctrl_q[CTRL_COND_LO +: 2]);
  assign wr_data  = wr_en && wr_idx == REG_DATA && ctrl_q[CTRL_DIR];

  // transfer qualifiers; the counter compare wraps modulo 16 bits
  assign time_ok  = !timed_q || count_q == time_q;
  assign cond_ok  = (cmode == COND_EQ) ? (pin_val == cond_q) :
                    (cmode == COND_NE) ? (pin_val != cond_q) : 1'b1;
  assign stb_ok   = !ctrl_q[CTRL_STB] || input_strobe;
  assign do_out   = tick && drive && state_q == XF_PEND && time_ok;
  assign do_in    = tick && enabled && !ctrl_q[CTRL_DIR] && state_q == XF_PEND
                    && time_ok && cond_ok && stb_ok;

  assign out_bits      = out_q;
  assign output_strobe = ostb_q;
  assign port_event    = state_q == XF_READY;

  // transfer sequencing; a new output word re-arms even while pending
  always_comb begin
    state_d = state_q;
    case (state_q)
      XF_IDLE:  if (enabled && !ctrl_q[CTRL_DIR]) state_d = XF_PEND;
      XF_PEND:  if (do_out) state_d = XF_IDLE;
                else if (do_in) state_d = XF_READY;
      XF_READY: if (rd_take) state_d = XF_PEND;
      default:  state_d = XF_IDLE;
    endcase
    if (wr_data) state_d = XF_PEND;
    if (!enabled) state_d = XF_IDLE;
  end

  // state, counter and configuration
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= XF_IDLE;
      ctrl_q  <= CTRL_RST;
      cond_q  <= '0;
      count_q <= '0;
    end else begin
      state_q <= state_d;
      if (tick) count_q <= count_q + 16'h0001;
      if (wr_en && wr_idx == REG_CTRL) ctrl_q <= wdata & CTRL_MASK;
      if (wr_en && wr_idx == REG_COND) cond_q <= wdata[W-1:0];
    end
  end

  // buffer path: transfer register and pin register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      xfer_q  <= '0;
      out_q   <= '0;
      stamp_q <= '0;
      time_q  <= '0;
      timed_q <= 1'b0;
      ostb_q  <= 1'b0;
    end else begin
      if (wr_data) xfer_q <= wdata[W-1:0];
      else if (do_in) xfer_q <= pin_val;
      if (do_out) out_q <= xfer_q;
      if (do_out || do_in) stamp_q <= count_q;
      if (wr_en && wr_idx == REG_TIME) begin
        time_q  <= wdata[COUNT_W-1:0];
        timed_q <= 1'b1;
      end else if (do_out || do_in) timed_q <= 1'b0;
      // strobe lasts one port clock period
      if (do_out) ostb_q <= 1'b1;
      else if (tick) ostb_q <= 1'b0;
    end
  end

  // read view
  always_comb begin
    case (rd_idx)
      REG_CTRL:   rdata = ctrl_q;
      REG_DATA:   rdata = 32'(xfer_q);
      REG_COND:   rdata = 32'(cond_q);
      REG_TIME:   rdata = 32'(time_q);
      REG_COUNT:  rdata = 32'(count_q);
      REG_STAMP:  rdata = 32'(stamp_q);
      REG_STATUS: rdata = {29'h0, timed_q, state_q};
      default:    rdata = 32'h0000_0000;
    endcase
  end

endmodule

// ---- hdl/port_tile.sv ----
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - ports of 1,4,8,16,32 bits, one direction
// - output drives pins; input samples, optional condition
// - each port access completes in one cycle
// - open collector: zero pulls low, one floats
// - data passes through transfer register and pin register; input here goes straight from the pins to the transfer register
// - 16-bit counter schedules pin transfers
// - counter readable; transfers delayed until count
// - counter captured as timestamp per transfer
// - enabled link disconnects underlying port pins
// - narrower enabled port owns shared pins
// - unshared pins stay with wider port
// - port always transfers at its full width
// - six clock blocks; block zero is reference
// - clock block sourced from 1-bit port, divided
// - input strobe qualifies, output strobe accompanies data
// - after reset ports use clock block zero
// - pin conditions raised as events, no interrupts
// - pull-downs enabled while reset held
module port_tile (
  // clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              rst_b,
  // ahb-lite slave
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic                              hready,
  input  wire logic [31:0]                       hwdata,
  output logic      [31:0]                       hrdata,
  output logic                                   hreadyout,
  output logic                                   hresp,
  // pins
  input  wire logic [port_pkg::NUM_PINS-1:0]     pin_in,
  output logic      [port_pkg::NUM_PINS-1:0]     pin_out,
  output logic      [port_pkg::NUM_PINS-1:0]     pin_oe,
  output logic      [port_pkg::NUM_PINS-1:0]     pin_pulldown,
  // strobes, one per port
  input  wire logic [port_pkg::NUM_PORTS-1:0]    input_strobe,
  output logic      [port_pkg::NUM_PORTS-1:0]    output_strobe,
  // events to the scheduler and link claim
  output logic      [port_pkg::NUM_PORTS-1:0]    port_event,
  output logic                                   link_active
);
  import port_pkg::*;

  // first enabled port in narrow-to-wide order wins the pin
  function automatic logic [2:0] pin_owner(input int p, input logic [NUM_PORTS-1:0] en);
    logic [2:0] own;
    own = NO_OWNER;
    for (int k = NUM_PORTS - 1; k >= 0; k--) begin
      if (en[k] && p >= PORT_LO[k] && p < PORT_LO[k] + PORT_W[k]) own = 3'(k);
    end
    return own;
  endfunction

  // bus, link and clock block state
  logic                    wr_pend_q;
  logic [11:0]             waddr_q;
  logic [31:0]             rdata_q;
  logic                    link_q;
  logic [31:0]             cb_cfg_q [NUM_CLKBLK];
  logic [CB_DIV_W-1:0]     cb_cnt_q [NUM_CLKBLK];
  logic [1:0]              src_prev_q;
  logic [NUM_CLKBLK-1:0]   cb_tick;

  // per-port views
  logic [31:0]             unit_rdata [NUM_PORTS];
  logic [31:0]             unit_out   [NUM_PORTS];
  logic [2:0]              unit_clk   [NUM_PORTS];
  logic [NUM_PORTS-1:0]    unit_en, unit_drive, unit_oc, unit_tick, unit_wr, unit_take;

  // address phase decode
  logic                    addr_ok;
  logic [3:0]              a_area;
  logic [2:0]              a_sel;
  logic [2:0]              a_idx;
  logic                    a_port;
  logic                    a_cb;
  logic                    a_link;
  logic [31:0]             rd_mux;

  assign addr_ok = hsel && hready && htrans[1];
  assign a_area  = haddr[11:8];
  assign a_sel   = haddr[7:5];
  assign a_idx   = haddr[4:2];
  assign a_port  = haddr[31:12] == 20'h0 && a_area == AREA_PORT && a_sel < 3'(NUM_PORTS);
  assign a_cb    = haddr[31:12] == 20'h0 && a_area == AREA_CLKBLK && haddr[7:5] == 3'h0
                   && a_idx < 3'(NUM_CLKBLK);
  assign a_link  = haddr[31:0] == 32'(LINK_CTRL);

  // data phase write decode, from the captured address
  logic                    w_port;
  logic                    w_cb;
  logic                    w_link;
  assign w_port = wr_pend_q && waddr_q[11:8] == AREA_PORT && waddr_q[7:5] < 3'(NUM_PORTS);
  assign w_cb   = wr_pend_q && waddr_q[11:8] == AREA_CLKBLK && waddr_q[7:5] == 3'h0;
  assign w_link = wr_pend_q && waddr_q == LINK_CTRL;

  // read selection; unmapped space reads zero
  assign rd_mux = a_port ? unit_rdata[a_sel] :
                  a_cb   ? cb_cfg_q[a_idx] :
                  a_link ? {31'h0, link_q} : 32'h0000_0000;

  // zero wait states so every port access finishes in one cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // read data is latched in the address phase; a read right after a
  // write to the same register sees the old value
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      waddr_q   <= 12'h000;
      rdata_q   <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok && hwrite && hsize == 3'h2;
      if (addr_ok) waddr_q <= haddr[11:0];
      if (addr_ok && !hwrite) rdata_q <= rd_mux;
    end
  end

  // link claim register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) link_q <= 1'b0;
    else if (w_link) link_q <= hwdata[0];
  end
  assign link_active = link_q;

  // 1-bit port pins as clock sources: pins are synchronous, plain edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) src_prev_q <= 2'b00;
    else src_prev_q <= pin_in[1:0];
  end

  // block zero is the reference rate itself and cannot be reprogrammed
  assign cb_tick[0] = 1'b1;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cb_cfg_q[0] <= CB_RST;
      cb_cnt_q[0] <= '0;
    end
  end

  genvar b;
  for (b = 1; b < NUM_CLKBLK; b++) begin : g_cb
    logic pin_sel;
    logic src_edge;
    logic src_tick;
    logic [CB_DIV_W-1:0] div;
    assign pin_sel  = cb_cfg_q[b][CB_PIN];
    assign src_edge = pin_in[pin_sel] && !src_prev_q[pin_sel];
    assign src_tick = cb_cfg_q[b][CB_EXT] ? src_edge : 1'b1;
    assign div      = cb_cfg_q[b][CB_DIV_LO +: CB_DIV_W];
    // divide by div+1 source edges
    assign cb_tick[b] = src_tick && cb_cnt_q[b] == div;
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        cb_cfg_q[b] <= CB_RST;
        cb_cnt_q[b] <= '0;
      end else begin
        if (w_cb && waddr_q[4:2] == 3'(b)) begin
          cb_cfg_q[b] <= hwdata & CB_MASK;
          cb_cnt_q[b] <= '0;
        end else if (cb_tick[b]) cb_cnt_q[b] <= '0;
        else if (src_tick) cb_cnt_q[b] <= cb_cnt_q[b] + 8'h01;
      end
    end
  end

  // link pins are hidden from the ports on the way in
  logic [NUM_PINS-1:0] link_mask;
  logic [NUM_PINS-1:0] pin_view;
  assign link_mask = link_q ? (32'(4'hf) << LINK_LO) : 32'h0000_0000;
  assign pin_view  = pin_in & ~link_mask;

  // reset holds every general-purpose pin pulled down
  assign pin_pulldown = {NUM_PINS{~rst_b}};

  // port instances, each with its full width of pins
  genvar k;
  for (k = 0; k < NUM_PORTS; k++) begin : g_port
    logic [PORT_W[k]-1:0] ob;
    assign unit_wr[k]   = w_port && waddr_q[7:5] == 3'(k);
    assign unit_take[k] = addr_ok && !hwrite && a_port && a_sel == 3'(k) && a_idx == REG_DATA;
    assign unit_tick[k] = unit_clk[k] < 3'(NUM_CLKBLK) && cb_tick[unit_clk[k]];
    assign unit_out[k]  = 32'(ob) << PORT_LO[k];
    port_unit #(
      .W(PORT_W[k])
    ) u_port (
      .ref_clk      (ref_clk),
      .rst_b        (rst_b),
      .tick         (unit_tick[k]),
      .wr_en        (unit_wr[k]),
      .wr_idx       (waddr_q[4:2]),
      .wdata        (hwdata),
      .rd_idx       (a_idx),
      .rd_take      (unit_take[k]),
      .rdata        (unit_rdata[k]),
      .pin_val      (pin_view[PORT_LO[k] +: PORT_W[k]]),
      .input_strobe (input_strobe[k]),
      .out_bits     (ob),
      .output_strobe(output_strobe[k]),
      .enabled      (unit_en[k]),
      .drive        (unit_drive[k]),
      .oc_mode      (unit_oc[k]),
      .clk_sel      (unit_clk[k]),
      .port_event   (port_event[k])
    );
  end

  // pin ownership and drive; a pin with no owner is left undriven
  genvar p;
  for (p = 0; p < NUM_PINS; p++) begin : g_pin
    logic [2:0] own;
    logic       bit_v;
    logic       drv;
    logic       oc;
    logic       in_link;
    assign in_link = link_q && p >= LINK_LO && p < LINK_LO + LINK_W;
    assign own     = in_link ? NO_OWNER : pin_owner(p, unit_en);
    assign bit_v   = own != NO_OWNER && unit_out[own][p];
    assign drv     = own != NO_OWNER && unit_drive[own];
    assign oc      = own != NO_OWNER && unit_oc[own];
    // open collector only ever drives a low
    assign pin_out[p] = oc ? 1'b0 : bit_v;
    assign pin_oe[p]  = drv && (!oc || !bit_v);
  end

endmodule

// ---- verif/port_tile_properties.sv ----
`timescale 1ns/1ps
module port_tile_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pins and status
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pin_pulldown,
  input wire logic [5:0]  output_strobe,
  input wire logic [5:0]  port_event,
  input wire logic        link_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // writes land one cycle after their address phase, and a control write moves
  // the port state one cycle later still, so three cycles count
  logic take;
  logic take_q;
  logic take_qq;
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      take_q  <= 1'b0;
      take_qq <= 1'b0;
    end else begin
      take_q  <= take;
      take_qq <= take_q;
    end
  end

  sequence s_rd(logic [31:0] a);
    take && !hwrite && haddr == a;
  endsequence

  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or error");
  // the release edge still samples reset low, so gate on the sampled level
  property p_pd_off;
    rst_b |-> pin_pulldown == 32'h0;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("pull-down on in run");
  property p_reset_quiet;
    $rose(rst_b) |-> pin_oe == 32'h0 && port_event == 6'h0 && output_strobe == 6'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
  property p_link_free;
    link_active |-> pin_oe[27:24] == 4'h0;
  endproperty
  a_link_free: assert property (p_link_free) else $error("link pins driven");
  property p_event_hold;
    port_event[4] && !take && !take_q && !take_qq |=> port_event[4];
  endproperty
  a_event_hold: assert property (p_event_hold) else $error("event dropped");
  property p_event_clear;
    s_rd(32'h84) ##0 port_event[4] |=> !port_event[4];
  endproperty
  a_event_clear: assert property (p_event_clear) else $error("event kept");
  property p_cb0_zero;
    s_rd(32'h100) |=> hrdata == 32'h0;
  endproperty
  a_cb0_zero: assert property (p_cb0_zero) else $error("block zero not 0");
  property p_width;
    s_rd(32'h4) |=> hrdata[31:1] == 31'h0;
  endproperty
  a_width: assert property (p_width) else $error("bits above port width");
  property p_rdata_hold;
    !(take && !hwrite) |=> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule

bind port_tile port_tile_checker port_tile_checker_inst (
  .ref_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
  .hresp, .pin_oe, .pin_pulldown, .output_strobe, .port_event, .link_active
);

// ---- verif/pin_partner.sv ----
`timescale 1ns/1ps
module pin_partner (
  // clock
  input  wire logic        ref_clk,
  // device side of the pins
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pin_pulldown,
  output logic      [31:0] pin_in,
  // external drivers set by the bench
  input  wire logic [31:0] ext_val,
  input  wire logic [31:0] ext_en,
  input  wire logic [5:0]  stb_req,
  output logic      [5:0]  input_strobe
);
  logic [31:0] float_q = 32'h0;
  // a floating line flips each cycle so stale data never looks valid
  always_ff @(posedge ref_clk) begin
    float_q <= ~pin_in;
  end
  // device driver first, then external driver, then pull-down, else floating
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & ~pin_pulldown & float_q);
  // strobe passed straight through from the bench request, separate from the data
  assign input_strobe = stb_req;
endmodule

// ---- verif/test_port_tile.sv ----
`timescale 1ns/1ps
module test_port_tile;
  import port_pkg::*;
  // clock, reset, bus
  logic        ref_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  // pins and partner controls
  logic [31:0] pin_in, pin_out, pin_oe, pin_pulldown;
  logic [31:0] ext_val = 32'h0;
  logic [31:0] ext_en  = 32'h0;
  logic [5:0]  stb_req = 6'h0;
  logic [5:0]  input_strobe, output_strobe, port_event;
  logic        link_active;
  logic [31:0] c1, c2, t;
  int          fail_count = 0;
  int          n_tests    = 0;
  int          stb_hi     = 0;

  port_tile port_tile_inst (
    .ref_clk, .rst_b, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hready, .hwdata, .hrdata, .hreadyout(hready), .hresp, .pin_in, .pin_out,
    .pin_oe, .pin_pulldown, .input_strobe, .output_strobe, .port_event, .link_active
  );
  pin_partner pin_partner_inst (
    .ref_clk, .pin_out, .pin_oe, .pin_pulldown, .pin_in, .ext_val, .ext_en,
    .stb_req, .input_strobe
  );

  always #(REF_PERIOD_NS / 2) ref_clk = ~ref_clk;
  // cycles of the outgoing strobe on the byte port
  always @(posedge ref_clk) begin
    if (output_strobe[3] === 1'b1) stb_hi++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one idle cycle before each transfer keeps reads clear of a prior write
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic t_reset_state;
    rst_b <= 1'b0;
    pause(10);
    chk(pin_pulldown, 32'hffff_ffff);
    chk(pin_oe, 32'h0);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int k = 0; k < NUM_PORTS; k++) begin
      rd_chk(32'h20 * k, CTRL_RST);
    end
    wr(32'h100, 32'h103);
    rd_chk(32'h100, 32'h0);
    rd_chk(32'h300, 32'h0);
  endtask
  task automatic t_output;
    wr(32'h60, 32'h3);
    stb_hi = 0;
    wr(32'h64, 32'ha5);
    pause(4);
    chk(pin_out & 32'hff, 32'ha5);
    chk(pin_oe & 32'hff, 32'hff);
    chk(stb_hi, 1);
    xfer(32'h70, 1'b0, 32'h0, c1);
    xfer(32'h70, 1'b0, 32'h0, c2);
    chk((c2 - c1) & 32'hffff, 32'h3);
    t = (c2 + 32'd40) & 32'hffff;
    wr(32'h6c, t);
    wr(32'h64, 32'h3c);
    pause(8);
    chk(pin_out & 32'hff, 32'ha5);
    pause(50);
    chk(pin_out & 32'hff, 32'h3c);
    rd_chk(32'h74, t);
  endtask
  task automatic t_open_drain;
    wr(32'h0, 32'h7);
    wr(32'h4, 32'h0);
    pause(4);
    chk(pin_oe & 32'hff, 32'hff);
    chk(pin_out & 32'hff, 32'h3c);
    wr(32'h4, 32'h1);
    pause(4);
    chk(pin_oe & 32'hff, 32'hfe);
    xfer(32'h4, 1'b0, 32'h0, c1);
    wr(32'h0, 32'h0);
    wr(32'h60, 32'h0);
  endtask
  task automatic t_input;
    ext_en  <= 32'hffff;
    ext_val <= 32'h1111;
    wr(32'h88, 32'h1234);
    wr(32'h80, 32'h109);
    pause(4);
    chk(port_event, 6'h0);
    @(posedge ref_clk);
    ext_val <= 32'h1234;
    pause(4);
    chk(port_event, 6'h0);
    @(posedge ref_clk);
    stb_req <= 6'h10;
    pause(4);
    chk(port_event, 6'h10);
    @(posedge ref_clk);
    stb_req <= 6'h0;
    rd_chk(32'h84, 32'h1234);
    pause(2);
    chk(port_event, 6'h0);
    // not-equal condition, strobe mode off: equal pins hold off the capture
    wr(32'h80, 32'h201);
    pause(4);
    chk(port_event, 6'h0);
    @(posedge ref_clk);
    ext_val <= 32'h1235;
    pause(4);
    chk(port_event, 6'h10);
    rd_chk(32'h84, 32'h1235);
    wr(32'h80, 32'h0);
  endtask
  task automatic t_link;
    ext_en <= 32'h0;
    wr(32'ha0, 32'h3);
    wr(32'ha4, 32'hffff_ffff);
    wr(LINK_CTRL, 32'h1);
    pause(4);
    chk(link_active, 1'b1);
    chk(pin_oe, 32'hf0ff_ffff);
    wr(LINK_CTRL, 32'h0);
    pause(4);
    chk(pin_oe, 32'hffff_ffff);
    wr(32'ha0, 32'h0);
  endtask
  task automatic t_clock_block;
    ext_en  <= 32'h2;
    ext_val <= 32'h0;
    wr(32'h104, 32'h103);
    wr(32'h0, 32'h13);
    xfer(32'h10, 1'b0, 32'h0, c1);
    pause(6);
    rd_chk(32'h10, c1);
    repeat (4) begin
      @(posedge ref_clk);
      ext_val <= 32'h2;
      @(posedge ref_clk);
      ext_val <= 32'h0;
    end
    pause(4);
    rd_chk(32'h10, (c1 + 32'h2) & 32'hffff);
    ext_en <= 32'h0;
  endtask

  task automatic tally_and_finish;
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    t_reset_state;
    t_output;
    t_open_drain;
    t_input;
    t_link;
    t_clock_block;
    t_reset_state;
    tally_and_finish;
  end
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish;
  end
endmodule
